// ### inc/fp_led_map.svh
// Timing counts and code constants for the front-panel indicator controller
`ifndef FP_LED_MAP_SVH
`define FP_LED_MAP_SVH

// Flash timing in milliseconds, converted to cycles at 125 MHz
`define FP_CLK_HZ 125000000
`define FP_FLASH_ON_MS 250
`define FP_FLASH_OFF_MS 250
`define FP_BURST_GAP_MS 2000
`define FP_FLASH_ON_CYC ((`FP_CLK_HZ / 1000) * `FP_FLASH_ON_MS)
`define FP_FLASH_OFF_CYC ((`FP_CLK_HZ / 1000) * `FP_FLASH_OFF_MS)
`define FP_BURST_GAP_CYC ((`FP_CLK_HZ / 1000) * `FP_BURST_GAP_MS)

// Flash counts per error code
`define FP_FLASH_SW_ERR 3'h2
`define FP_FLASH_SAFE 3'h3
`define FP_FLASH_CRASH2 3'h4

// Counter width for the timing counters
`define FP_CNT_W 32

`endif

// ### inc/fp_led_pkg.sv
// Types shared by the front-panel indicator controller
package fp_led_pkg;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ON = 2'b01,
		ST_GAP = 2'b10
	} flash_state_t;

	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_GREEN = 2'b01,
		PWR_RED = 2'b10
	} pwr_colour_t;

endpackage : fp_led_pkg

// ### rtl/tri_led_drive.sv
// One tri-colour indicator: two independent registered enables
`timescale 1ns/1ps
`default_nettype none

module tri_led_drive (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Software enables
	input wire logic green_en_i,
	input wire logic red_en_i,
	// LED drives
	output logic green_o,
	output logic red_o
);

	typedef struct packed {
		logic green;
		logic red;
	} tri_state_t;

	tri_state_t state_r;
	tri_state_t state_nxt;

	// Both clear is off, both set mixes to yellow
	always_comb begin
		state_nxt = state_r;
		state_nxt.green = green_en_i; // [R12]
		state_nxt.red = red_en_i; // [R12]
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign green_o = state_r.green;
	assign red_o = state_r.red;

	AST_TRI_FOLLOW: assert property ( // [R12]
		@(posedge clock_i) disable iff (!resetn_i)
		##1 ({green_o, red_o} == $past({green_en_i, red_en_i})))
		else $error("Tri-colour LED does not follow its enables");

endmodule : tri_led_drive

`default_nettype wire

// ### rtl/front_panel_indicator_controller.sv
// Front-panel indicator controller: power, status, tri-colour, safety LEDs
//
// Overview of operation
// (R01) Power LED dark when supply invalid
// (R02) Power LED green when valid, no fault
// (R03) Brownout: red LED, rail and outputs off
// (R04) Status LED off with no error pending
// (R05) Self test lights power and status LEDs
// (R06) Errors flash code bursts, repeated periodically
// (R07) Software integrity error gives two flashes
// (R08) Safe mode gives three flashes
// (R09) Double crash gives four flashes
// (R10) Unrecoverable error: continuous flashing or solid
// (R11) Software alone sets tri-colour indicators
// (R12) Two enables: off, green, red, yellow
// (R13) Radio LED undefined without USB radio
// (R14) Safety LED mirrors robot safety light
// (R15) Timing parameters; code changes at boundaries
// (R16) Priority: fatal, crash, software, safe mode
`timescale 1ns/1ps
`default_nettype none
`include "fp_led_map.svh"

module front_panel_indicator_controller #(
	parameter int unsigned FLASH_ON_CYC = `FP_FLASH_ON_CYC,
	parameter int unsigned FLASH_OFF_CYC = `FP_FLASH_OFF_CYC,
	parameter int unsigned BURST_GAP_CYC = `FP_BURST_GAP_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Power supervision
	input wire logic supply_valid_i,
	input wire logic brownout_i,
	input wire logic fault_i,
	// Self-test sequencer
	input wire logic power_on_self_test_i,
	// Error conditions
	input wire logic sw_integrity_err_i,
	input wire logic safe_mode_i,
	input wire logic double_crash_i,
	input wire logic fatal_err_i,
	input wire logic fatal_solid_i,
	// Software enables for the tri-colour indicators
	input wire logic radio_green_en_i,
	input wire logic radio_red_en_i,
	input wire logic comm_green_en_i,
	input wire logic comm_red_en_i,
	input wire logic mode_green_en_i,
	input wire logic mode_red_en_i,
	// External safety light
	input wire logic robot_safety_light_i,
	// Power indicator and rail control
	output logic power_green_o,
	output logic power_red_o,
	output logic user_rail_en_o,
	output logic outputs_en_o,
	// Status and safety indicators
	output logic status_o,
	output logic safety_o,
	// Tri-colour indicators
	output logic radio_green_o,
	output logic radio_red_o,
	output logic comm_green_o,
	output logic comm_red_o,
	output logic mode_green_o,
	output logic mode_red_o
);

	localparam int CW = `FP_CNT_W;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		fp_led_pkg::flash_state_t fsm;
		logic [CW-1:0] timer;
		logic [2:0] remain;
		logic [2:0] code;
		logic fatal;
		logic solid;
		fp_led_pkg::pwr_colour_t pwr;
		logic rail_en;
		logic status;
		logic safety;
	} panel_state_t;

	panel_state_t st_r;
	panel_state_t st_nxt;

	logic [2:0] req_code;
	logic err_any;

	// Highest-priority error chooses the flash count
	always_comb begin
		req_code = 3'h0;
		if (double_crash_i) begin // [R16]
			req_code = `FP_FLASH_CRASH2; // [R09]
		end else if (sw_integrity_err_i) begin
			req_code = `FP_FLASH_SW_ERR; // [R07]
		end else if (safe_mode_i) begin
			req_code = `FP_FLASH_SAFE; // [R08]
		end
	end

	assign err_any = fatal_err_i || (req_code != 3'h0);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.safety = robot_safety_light_i; // [R14]

		// Brownout dominates: red and all outputs dropped
		if (brownout_i) begin
			st_nxt.pwr = fp_led_pkg::PWR_RED; // [R03]
			st_nxt.rail_en = 1'b0; // [R03]
		end else if (!supply_valid_i) begin
			st_nxt.pwr = fp_led_pkg::PWR_OFF; // [R01]
			st_nxt.rail_en = 1'b0;
		end else if (power_on_self_test_i) begin
			st_nxt.pwr = fp_led_pkg::PWR_GREEN; // [R05]
			st_nxt.rail_en = 1'b1;
		end else if (!fault_i) begin
			st_nxt.pwr = fp_led_pkg::PWR_GREEN; // [R02]
			st_nxt.rail_en = 1'b1;
		end else begin
			st_nxt.pwr = fp_led_pkg::PWR_OFF;
			st_nxt.rail_en = 1'b1;
		end

		// Flash sequencer; a new error is sampled only at a burst boundary
		case (st_r.fsm)
			fp_led_pkg::ST_GAP: begin
				if (st_r.timer != '0) begin
					st_nxt.timer = st_r.timer - 1'b1;
				end else if (err_any) begin // [R15]
					st_nxt.fatal = fatal_err_i; // [R16]
					st_nxt.solid = fatal_solid_i;
					st_nxt.code = req_code;
					st_nxt.remain = fatal_err_i ? 3'h1 : req_code;
					st_nxt.fsm = fp_led_pkg::ST_ON;
					st_nxt.timer = CW'(FLASH_ON_CYC - 1);
				end else begin
					st_nxt.code = 3'h0;
					st_nxt.fatal = 1'b0;
				end
			end
			fp_led_pkg::ST_ON: begin
				if (st_r.timer != '0) begin
					st_nxt.timer = st_r.timer - 1'b1;
				end else begin
					st_nxt.fsm = fp_led_pkg::ST_OFF;
					st_nxt.timer = CW'(FLASH_OFF_CYC - 1);
					st_nxt.remain = st_r.remain - 1'b1;
				end
			end
			fp_led_pkg::ST_OFF: begin
				if (st_r.timer != '0) begin
					st_nxt.timer = st_r.timer - 1'b1;
				end else if (st_r.remain != 3'h0) begin
					st_nxt.fsm = fp_led_pkg::ST_ON;
					st_nxt.timer = CW'(FLASH_ON_CYC - 1);
				end else if (st_r.fatal && fatal_err_i) begin
					// Fatal flashes continuously, no gap
					st_nxt.fsm = fp_led_pkg::ST_ON; // [R10]
					st_nxt.remain = 3'h1;
					st_nxt.solid = fatal_solid_i;
					st_nxt.timer = CW'(FLASH_ON_CYC - 1);
				end else begin
					st_nxt.fsm = fp_led_pkg::ST_GAP; // [R06]
					st_nxt.timer = CW'(BURST_GAP_CYC - 1);
				end
			end
			default: begin
				st_nxt.fsm = fp_led_pkg::ST_GAP;
				st_nxt.timer = '0;
			end
		endcase

		// Self test wins over codes; no error leaves the LED dark
		if (power_on_self_test_i) begin
			st_nxt.status = 1'b1; // [R05]
		end else if (st_r.fatal && st_r.solid) begin
			st_nxt.status = 1'b1; // [R10]
		end else begin
			st_nxt.status = (st_nxt.fsm == fp_led_pkg::ST_ON); // [R04] [R06]
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '{fsm: fp_led_pkg::ST_GAP, pwr: fp_led_pkg::PWR_OFF,
				default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Colour codes are one-hot, so each lamp is one state bit, glitch free
	assign power_green_o = st_r.pwr[0];
	assign power_red_o = st_r.pwr[1];
	assign user_rail_en_o = st_r.rail_en;
	assign outputs_en_o = st_r.rail_en;
	assign status_o = st_r.status;
	assign safety_o = st_r.safety;

	// Pure software configuration; radio state is meaningless without a radio
	tri_led_drive u_radio ( // [R11] [R13]
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.green_en_i(radio_green_en_i),
		.red_en_i(radio_red_en_i),
		.green_o(radio_green_o),
		.red_o(radio_red_o)
	);

	tri_led_drive u_comm ( // [R11]
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.green_en_i(comm_green_en_i),
		.red_en_i(comm_red_en_i),
		.green_o(comm_green_o),
		.red_o(comm_red_o)
	);

	tri_led_drive u_mode ( // [R11]
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.green_en_i(mode_green_en_i),
		.red_en_i(mode_red_en_i),
		.green_o(mode_green_o),
		.red_o(mode_red_o)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_burst_start;
		st_r.fsm == fp_led_pkg::ST_GAP && st_r.timer == '0 && err_any;
	endsequence

	AST_PWR_DARK: assert property ( // [R01]
		@(posedge clock_i) disable iff (!resetn_i)
		(!supply_valid_i && !brownout_i) |=> !power_green_o && !power_red_o)
		else $error("Power LED lit with invalid supply");

	AST_PWR_GREEN: assert property ( // [R02]
		@(posedge clock_i) disable iff (!resetn_i)
		(supply_valid_i && !brownout_i && !fault_i) |=>
		power_green_o && !power_red_o)
		else $error("Power LED not green with valid supply");

	AST_BROWNOUT: assert property ( // [R03]
		@(posedge clock_i) disable iff (!resetn_i)
		brownout_i |=> power_red_o && !power_green_o && !user_rail_en_o
		&& !outputs_en_o)
		else $error("Brownout not shown or rails left on");

	// A gap that ends with an error pending starts a burst on the next edge
	AST_IDLE_DARK: assert property ( // [R04]
		@(posedge clock_i) disable iff (!resetn_i)
		(st_r.fsm == fp_led_pkg::ST_GAP && !power_on_self_test_i
		&& !st_r.fatal && !(st_r.timer == '0 && err_any)) |=> !status_o)
		else $error("Status LED lit outside a burst");

	AST_SELF_TEST: assert property ( // [R05]
		@(posedge clock_i) disable iff (!resetn_i)
		(power_on_self_test_i && supply_valid_i && !brownout_i) |=>
		status_o && power_green_o)
		else $error("Self test does not light both LEDs");

	AST_CODE_PRIO: assert property ( // [R09] [R16]
		@(posedge clock_i) disable iff (!resetn_i)
		(s_burst_start and (double_crash_i && !fatal_err_i)) |=>
		st_r.remain == `FP_FLASH_CRASH2)
		else $error("Double crash not given four flashes");

	AST_CODE_SW: assert property ( // [R07]
		@(posedge clock_i) disable iff (!resetn_i)
		(s_burst_start and (sw_integrity_err_i && !double_crash_i
		&& !fatal_err_i)) |=> st_r.remain == `FP_FLASH_SW_ERR)
		else $error("Software error not given two flashes");

	AST_CODE_SAFE: assert property ( // [R08]
		@(posedge clock_i) disable iff (!resetn_i)
		(s_burst_start and (safe_mode_i && !sw_integrity_err_i
		&& !double_crash_i && !fatal_err_i)) |=>
		st_r.remain == `FP_FLASH_SAFE)
		else $error("Safe mode not given three flashes");

	AST_BURST_GAP: assert property ( // [R06] [R15]
		@(posedge clock_i) disable iff (!resetn_i)
		(st_r.fsm == fp_led_pkg::ST_OFF && st_r.timer == '0
		&& st_r.remain == 3'h0 && !(st_r.fatal && fatal_err_i)) |=>
		st_r.fsm == fp_led_pkg::ST_GAP)
		else $error("Burst not followed by a gap");

	AST_FATAL_SOLID: assert property ( // [R10]
		@(posedge clock_i) disable iff (!resetn_i)
		(st_r.fatal && st_r.solid && !power_on_self_test_i) |=> status_o)
		else $error("Solid fatal indication not lit");

	AST_SAFETY: assert property ( // [R14]
		@(posedge clock_i) disable iff (!resetn_i)
		##1 safety_o == $past(robot_safety_light_i))
		else $error("Safety LED does not mirror the light");

endmodule : front_panel_indicator_controller

`default_nettype wire

// ### testbench/sw_led_cfg.sv
// Software model that sets the tri-colour indicator enables
`timescale 1ns/1ps
`default_nettype none
module sw_led_cfg (
	// Configuration word from the bench
	input wire logic [5:0] cfg_i,
	// Enables towards the controller
	output logic radio_green_en_o,
	output logic radio_red_en_o,
	output logic comm_green_en_o,
	output logic comm_red_en_o,
	output logic mode_green_en_o,
	output logic mode_red_en_o
);
	// ************************************************
	// Enables come from configuration only
	// ************************************************
	assign {radio_green_en_o, radio_red_en_o} = cfg_i[5:4];
	assign {comm_green_en_o, comm_red_en_o} = cfg_i[3:2];
	assign {mode_green_en_o, mode_red_en_o} = cfg_i[1:0];
endmodule : sw_led_cfg
`default_nettype wire

// ### testbench/tb_front_panel_indicator_controller.sv
// Self-checking bench for the front-panel indicator controller
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_indicator_controller;
	// ************************************************
	// Stimulus, checks and verdict
	// ************************************************
	logic clock_i, resetn_i, sv, bo, flt, power_on_self_test, swe, safe, crash, fatal;
	logic solid, robot_safety_light, pg, pr, ure, oen, st, sf, rg, rr, cg, cr, mg, mr;
	logic rge, rre, cge, cre, mge, mre;
	logic [5:0] cfg;
	logic [7:0] n, hi;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;

	sw_led_cfg sw_u (.cfg_i(cfg), .radio_green_en_o(rge),
		.radio_red_en_o(rre), .comm_green_en_o(cge), .comm_red_en_o(cre),
		.mode_green_en_o(mge), .mode_red_en_o(mre));

	// Short counts keep a full four-flash burst cycle near thirty clocks
	front_panel_indicator_controller #(.FLASH_ON_CYC(3),
		.FLASH_OFF_CYC(2), .BURST_GAP_CYC(10)) dut_u (
		.clock_i(clock_i), .resetn_i(resetn_i), .supply_valid_i(sv),
		.brownout_i(bo), .fault_i(flt), .power_on_self_test_i(power_on_self_test),
		.sw_integrity_err_i(swe), .safe_mode_i(safe),
		.double_crash_i(crash), .fatal_err_i(fatal),
		.fatal_solid_i(solid), .radio_green_en_i(rge),
		.radio_red_en_i(rre), .comm_green_en_i(cge), .comm_red_en_i(cre),
		.mode_green_en_i(mge), .mode_red_en_i(mre),
		.robot_safety_light_i(robot_safety_light), .power_green_o(pg), .power_red_o(pr),
		.user_rail_en_o(ure), .outputs_en_o(oen), .status_o(st),
		.safety_o(sf), .radio_green_o(rg), .radio_red_o(rr),
		.comm_green_o(cg), .comm_red_o(cr), .mode_green_o(mg),
		.mode_red_o(mr));

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic settle;
		repeat (2) @(negedge clock_i);
	endtask : settle

	task automatic pw(input logic v, b, f, eg, er, ea);
		{sv, bo, flt} = {v, b, f};
		settle();
		chk({pg, pr}, {eg, er});
		if (ea !== 1'bx)
			chk({ure, oen}, {ea, ea});
	endtask : pw

	// Counts rises of the status LED over a window
	task automatic rises(input int len, output logic [7:0] r);
		logic p;
		p = st;
		r = 0;
		repeat (len) begin
			@(negedge clock_i);
			if (st && !p)
				r++;
			p = st;
		end
	endtask : rises

	// Eight quiet cycles can only be a gap, since the off phase is two
	task automatic burst(output logic [7:0] r, output logic [7:0] h);
		int q, w;
		logic p;
		q = 0;
		w = 0;
		r = 0;
		h = 0;
		while (q < 8 && w < 200) begin
			@(negedge clock_i);
			q = st ? 0 : q + 1;
			w++;
		end
		q = 0;
		p = 1'b0;
		while ((q < 8 || r == 0) && w < 400) begin
			@(negedge clock_i);
			if (st && !p)
				r++;
			if (st)
				h++;
			q = st ? 0 : q + 1;
			p = st;
			w++;
		end
	endtask : burst

	task automatic burst_code(input logic [2:0] m, input logic [7:0] e);
		{crash, swe, safe} = m;
		burst(n, hi);
		burst(n, hi);
		chk(n, e);
		chk(hi, e * 8'h03);
	endtask : burst_code

	task finish_test;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	initial begin
		{resetn_i, bo, flt, swe, safe, crash, fatal, solid, robot_safety_light} = 0;
		{sv, power_on_self_test} = 2'b11;
		cfg = 6'h00;
		repeat (16) @(negedge clock_i);
		resetn_i = 1'b1;
		settle();
		chk({pg, st}, 8'h03);
		power_on_self_test = 1'b0;
		settle();
		chk(st, 8'h00);
		rises(40, n);
		chk(n, 8'h00);
		pw(0, 0, 0, 0, 0, 1'bx);
		pw(1, 1, 0, 0, 1, 0);
		pw(1, 0, 1, 0, 0, 1);
		pw(1, 0, 0, 1, 0, 1);
		burst_code(3'b010, 8'h02);
		burst_code(3'b001, 8'h03);
		burst_code(3'b100, 8'h04);
		burst_code(3'b111, 8'h04);
		burst_code(3'b011, 8'h02);
		fatal = 1'b1;
		repeat (40) @(negedge clock_i);
		rises(40, n);
		chk(n, 8'h08);
		solid = 1'b1;
		repeat (40) @(negedge clock_i);
		rises(20, n);
		chk(n, 8'h00);
		chk({7'h00, st}, 8'h01);
		{fatal, crash, swe, safe} = 0;
		for (int i = 0; i < 64; i++) begin
			cfg = i[5:0];
			settle();
			chk({rg, rr, cg, cr, mg, mr}, {2'b00, cfg});
		end
		for (int i = 0; i < 2; i++) begin
			robot_safety_light = i[0];
			settle();
			chk(sf, robot_safety_light);
		end
		finish_test();
	end
endmodule : tb_front_panel_indicator_controller
`default_nettype wire
